/* File: boot_seq_pkg.sv */
// constants, carriers and state layout for the drive bootstrap read-in sequencer
package boot_seq_pkg;

  // word path and device addressing
  localparam int WORD_W = 36;
  typedef logic [WORD_W-1:0] word_t;
  localparam int DEV_CODE_W = 9;
  localparam logic [DEV_CODE_W-1:0] BOOT_DEV_CODE = 9'h0b8; // 270 octal
  localparam int DRV_SEL_W = 3;
  localparam int DRV_REG_W = 5;
  localparam int DRV_CMD_W = 16;
  localparam logic [DRV_REG_W-1:0] DRV_REG_CTRL = 5'h00;
  localparam logic [DRV_CMD_W-1:0] CMD_PRESET = 16'h0011; // 21 octal
  localparam logic [DRV_CMD_W-1:0] CMD_READ = 16'h0039; // 71 octal

  // timing
  localparam int CLK_MHZ = 100;
  localparam int INIT_NS = 400;
  localparam int INIT_CYC = (INIT_NS * CLK_MHZ + 999) / 1000;
  localparam int INIT_CNT_W = $clog2(INIT_CYC + 1);

  // wishbone register map (byte addresses)
  localparam int ADR_W = 4;
  localparam logic [ADR_W-1:0] ADR_CTRL = 4'h0;
  localparam logic [ADR_W-1:0] ADR_STATUS = 4'h4;
  localparam logic [ADR_W-1:0] ADR_DATA = 4'h8;
  localparam logic [ADR_W-1:0] ADR_WORD_MASK = 4'hc;

  // indices into the synchroniser vector
  localparam int SY_RESET = 0;
  localparam int SY_START = 1;
  localparam int SY_CPU_DATA_IN = 2;
  localparam int SY_GRANT = 3;
  localparam int SY_XFER = 4;
  localparam int SY_OCC = 5;
  localparam int SY_SCLK = 6;
  localparam int SY_EBL = 7;
  localparam int SY_N = 8;

  typedef enum logic [3:0] {
    S_IDLE       = 4'b0000,
    S_ARMED      = 4'b0001,
    S_PRESET_DEM = 4'b0010,
    S_PRESET_REL = 4'b0011,
    S_WAIT_CTL   = 4'b0100,
    S_CTL_DEM    = 4'b0101,
    S_CTL_REL    = 4'b0110,
    S_RUN        = 4'b0111,
    S_DATA       = 4'b1000,
    S_PTR_READY  = 4'b1001,
    S_LAST_LOAD  = 4'b1010,
    S_LAST_READY = 4'b1011
  } seq_e;

  // drive control-bus carrier
  typedef struct packed {
    logic [DRV_SEL_W-1:0] sel;
    logic [DRV_REG_W-1:0] reg_addr;
    logic [DRV_CMD_W-1:0] data;
    logic write;
    logic demand;
  } drive_ctl_s;

  // status register layout
  typedef struct packed {
    logic [15:0] zero;
    logic [3:0] seq;
    logic xfer_terminate;
    logic xfer_complete;
    logic ar_full;
    logic chan_buf_full;
    logic boot_read_seen;
    logic boot_word_ready;
    logic chan_seized;
    logic chan_active_flag;
    logic chan_request_pending;
    logic ctl_done_flag;
    logic ctl_busy_flag;
    logic boot_active_flag;
  } status_s;

  // complete state of the sequencer
  typedef struct packed {
    logic [SY_N-1:0] sync1;
    logic [SY_N-1:0] sync2;
    logic [SY_N-1:0] prev;
    word_t data_s1;
    word_t data_s2;
    logic [DEV_CODE_W-1:0] code_s1;
    logic [DEV_CODE_W-1:0] code_s2;
    seq_e seq;
    logic [INIT_CNT_W-1:0] init_cnt;
    logic drive_init_out;
    logic power_clear;
    logic [DRV_SEL_W-1:0] panel_drive;
    logic boot_active_flag;
    logic boot_read_seen;
    logic boot_word_ready;
    logic boot_end_pulse;
    logic boot_xfer_done;
    drive_ctl_s drive_ctl;
    logic reg_buffer_load;
    logic ctl_cycle_req;
    logic run;
    logic xfer_start;
    logic chan_request_pending;
    logic chan_active_flag;
    logic chan_start_out;
    logic chan_seized;
    logic chan_boot_mode;
    logic chan_boot_mode_pulse;
    logic chan_pulse_flag;
    logic chan_pulse_seen;
    logic dev_word_pulse;
    word_t bus_data_reg;
    word_t assembly_reg;
    word_t channel_buffer;
    logic chan_buf_full;
    logic ar_full;
    logic chan_buf_load;
    logic ctl_busy_flag;
    logic ctl_done_flag;
    logic xfer_finish_enable;
    logic xfer_finish;
    logic xfer_terminate;
    logic xfer_complete;
    logic wb_ack;
    logic [31:0] wb_dat;
  } state_s;

endpackage

/* File: boot_seq_props.sv */
// assertion checker on the read-in sequencer's ports, bound to the design
`timescale 1ns/1ps
module boot_seq_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic iob_reset_i,
  input wire logic power_clear_o,
  input wire logic drive_init_out_o,
  input wire logic chan_granted_in_i,
  input wire logic chan_start_out_o,
  input wire logic chan_boot_mode_o,
  input wire logic dev_word_pulse_o,
  input wire boot_seq_pkg::drive_ctl_s drive_ctl_o
);
  import boot_seq_pkg::*;
  // every check runs on the system clock and sleeps through reset
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // grant recognised: start request drops, read-in mode follows
  sequence s_grant_seen;
    $fell(chan_start_out_o) ##[0:2] chan_boot_mode_o;
  endsequence
  // a fresh demand on the drive control bus
  sequence s_new_demand;
    $rose(drive_ctl_o.demand);
  endsequence
  // bus handshake
  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  ack_answers_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered in one cycle");
  rdata_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero outside ack");
  // bus reset handling
  pclr_follows_a: assert property ($rose(iob_reset_i) |-> ##[1:6] power_clear_o)
    else $error("no power clear after bus reset");
  pclr_single_a: assert property (power_clear_o |=> !power_clear_o)
    else $error("power clear wider than one cycle");
  init_follows_a: assert property (power_clear_o |-> ##[0:2] drive_init_out_o ##1 drive_init_out_o [*8])
    else $error("drive initialise missing or short");
  // channel request and grant
  start_holds_a: assert property (chan_start_out_o && !chan_granted_in_i |=> chan_start_out_o)
    else $error("start request dropped before grant");
  grant_mode_a: assert property ($rose(chan_granted_in_i) && chan_start_out_o |-> ##[1:6] s_grant_seen)
    else $error("grant did not give read-in mode");
  // drive control cycles and the channel word pulse
  preset_cmd_a: assert property (s_new_demand ##0 !chan_boot_mode_o |->
    drive_ctl_o.data == CMD_PRESET && drive_ctl_o.write && drive_ctl_o.reg_addr == DRV_REG_CTRL)
    else $error("first demand is not the preset write");
  read_cmd_a: assert property (s_new_demand ##0 chan_boot_mode_o |-> drive_ctl_o.data == CMD_READ)
    else $error("demand after grant is not the read command");
  ctl_stable_a: assert property (s_new_demand |=> $stable(drive_ctl_o) [*3])
    else $error("control bus changed during demand");
  word_pulse_a: assert property (dev_word_pulse_o |=> !dev_word_pulse_o)
    else $error("word pulse wider than one cycle");
endmodule
bind drive_bootstrap_readin_sequencer boot_seq_props boot_seq_props_i (.clk_i, .rst_i, .wb_cyc_i,
  .wb_stb_i, .wb_dat_o, .wb_ack_o, .iob_reset_i, .power_clear_o, .drive_init_out_o, .chan_granted_in_i,
  .chan_start_out_o, .chan_boot_mode_o, .dev_word_pulse_o, .drive_ctl_o);

/* File: drive_bootstrap_readin_sequencer.sv */
// read-in sequencer: loads a bootstrap block from a drive and hands two words to the processor
`timescale 1ns/1ps

module drive_bootstrap_readin_sequencer (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [boot_seq_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic iob_reset_i,
  input wire logic boot_start_pulse_i,
  input wire logic [boot_seq_pkg::DEV_CODE_W-1:0] iob_dev_code_i,
  input wire logic cpu_data_in_i,
  output logic boot_word_ready_out_o,
  output boot_seq_pkg::word_t cpu_data_o,
  output logic power_clear_o,
  input wire logic chan_granted_in_i,
  output logic chan_start_out_o,
  output logic chan_boot_mode_o,
  output logic dev_word_pulse_o,
  output boot_seq_pkg::word_t chan_data_o,
  output boot_seq_pkg::drive_ctl_s drive_ctl_o,
  input wire logic drive_transfer_i,
  output logic drive_run_o,
  output logic drive_init_out_o,
  input wire logic drive_occupied_i,
  input wire logic drive_sclk_i,
  input wire logic end_of_block_i,
  input wire boot_seq_pkg::word_t drive_data_i
);
  import boot_seq_pkg::*;

  state_s st_reg;
  state_s st_next;
  logic [SY_N-1:0] rise;
  logic [SY_N-1:0] fall;
  status_s status;

  // edges come only from the second synchroniser stage and its delayed copy
  assign rise = st_reg.sync2 & ~st_reg.prev;
  assign fall = ~st_reg.sync2 & st_reg.prev;

  // status view of the block's own flags
  always_comb begin
    status = '0;
    status.seq = st_reg.seq;
    status.xfer_terminate = st_reg.xfer_terminate;
    status.xfer_complete = st_reg.xfer_complete;
    status.ar_full = st_reg.ar_full;
    status.chan_buf_full = st_reg.chan_buf_full;
    status.boot_read_seen = st_reg.boot_read_seen;
    status.boot_word_ready = st_reg.boot_word_ready;
    status.chan_seized = st_reg.chan_seized;
    status.chan_active_flag = st_reg.chan_active_flag;
    status.chan_request_pending = st_reg.chan_request_pending;
    status.ctl_done_flag = st_reg.ctl_done_flag;
    status.ctl_busy_flag = st_reg.ctl_busy_flag;
    status.boot_active_flag = st_reg.boot_active_flag;
  end

  // next-state logic for the whole sequencer
  always_comb begin
    st_next = st_reg;

    // two-stage synchronisers for every pin from outside the clock domain
    st_next.sync1 = {end_of_block_i, drive_sclk_i, drive_occupied_i, drive_transfer_i,
                     chan_granted_in_i, cpu_data_in_i, boot_start_pulse_i, iob_reset_i};
    st_next.sync2 = st_reg.sync1;
    st_next.prev = st_reg.sync2;
    st_next.data_s1 = drive_data_i;
    st_next.data_s2 = st_reg.data_s1;
    st_next.code_s1 = iob_dev_code_i;
    st_next.code_s2 = st_reg.code_s1;

    // strobes last exactly one cycle
    st_next.power_clear = 1'b0;
    st_next.reg_buffer_load = 1'b0;
    st_next.xfer_start = 1'b0;
    st_next.chan_boot_mode_pulse = 1'b0;
    st_next.dev_word_pulse = 1'b0;
    st_next.chan_buf_load = 1'b0;
    st_next.boot_xfer_done = 1'b0;
    st_next.boot_end_pulse = 1'b0;
    st_next.xfer_finish = 1'b0;
    st_next.xfer_finish_enable = 1'b0;

    // wishbone slave: one wait state, ack dropped the cycle after it was given
    st_next.wb_ack = wb_cyc_i & wb_stb_i & ~st_reg.wb_ack;
    st_next.wb_dat = '0;
    if (wb_cyc_i && wb_stb_i && !st_reg.wb_ack) begin
      case (wb_adr_i & ADR_WORD_MASK)
        ADR_CTRL: begin
          st_next.wb_dat = {{(32-DRV_SEL_W){1'b0}}, st_reg.panel_drive};
          if (wb_we_i && wb_sel_i[0]) begin
            st_next.panel_drive = wb_dat_i[DRV_SEL_W-1:0];
          end
        end
        ADR_STATUS: st_next.wb_dat = status;
        ADR_DATA: st_next.wb_dat = st_reg.channel_buffer[31:0];
        default: st_next.wb_dat = '0; // unmapped reads as zero, writes ignored
      endcase
    end

    // drive initialise stretch after power clear
    if (st_reg.init_cnt != '0) begin
      st_next.init_cnt = st_reg.init_cnt - 1'b1;
    end
    st_next.drive_init_out = (st_next.init_cnt != '0);

    // register buffer takes the preset command one cycle after the load strobe
    if (st_reg.reg_buffer_load) begin
      st_next.drive_ctl.data = CMD_PRESET;
      st_next.drive_ctl.reg_addr = DRV_REG_CTRL;
    end

    // channel request: transfer start sets pending; a free channel goes active
    if (st_reg.xfer_start) begin
      st_next.chan_request_pending = 1'b1;
      if (!st_reg.chan_active_flag) begin
        st_next.chan_active_flag = 1'b1;
        st_next.chan_start_out = 1'b1;
      end
    end

    // channel grants itself: seized, pending cleared, read-in mode announced
    if (rise[SY_GRANT] && st_reg.chan_active_flag) begin
      st_next.chan_seized = 1'b1;
      st_next.chan_request_pending = 1'b0;
      st_next.chan_start_out = 1'b0;
      if (st_reg.boot_active_flag) begin
        st_next.chan_boot_mode = 1'b1;
        st_next.chan_boot_mode_pulse = 1'b1;
      end
    end

    // channel drops busy-in: it has terminated, the channel is inactive again
    if (fall[SY_GRANT] && st_reg.chan_seized) begin
      st_next.chan_seized = 1'b0;
      st_next.chan_active_flag = 1'b0;
    end

    // own pulse replaces the channel's; word pulses toggle the flag
    if (st_reg.chan_boot_mode_pulse) begin
      st_next.chan_pulse_flag = 1'b1;
      st_next.chan_pulse_seen = 1'b1;
    end else if (st_reg.dev_word_pulse) begin
      st_next.chan_pulse_flag = ~st_reg.chan_pulse_flag;
    end

    // finish follows finish-enable by one cycle
    if (rise[SY_EBL] && st_reg.ctl_busy_flag) begin
      st_next.xfer_finish_enable = 1'b1;
    end
    if (st_reg.xfer_finish_enable) begin
      st_next.xfer_finish = 1'b1;
    end
    if (st_reg.xfer_finish) begin
      st_next.ctl_busy_flag = 1'b0;
      st_next.ctl_done_flag = 1'b1;
      st_next.run = 1'b0;
    end

    // terminate and complete are levels derived from registered flags
    st_next.xfer_terminate = st_reg.chan_buf_full & st_reg.ar_full & ~st_reg.chan_active_flag;
    st_next.xfer_complete = st_reg.ctl_done_flag & ~st_reg.ctl_busy_flag
                            & ~st_reg.chan_active_flag;

    // main sequence
    case (st_reg.seq)
      S_IDLE: begin
        if (rise[SY_START] && st_reg.code_s2 == BOOT_DEV_CODE) begin
          st_next.boot_active_flag = 1'b1;
          st_next.drive_ctl.sel = st_reg.panel_drive;
          st_next.drive_ctl.write = 1'b1;
          st_next.ctl_done_flag = 1'b0;
          st_next.seq = S_ARMED;
        end
      end
      S_ARMED: begin
        // trailing edge of the start pulse loads the buffer and starts the channel
        if (fall[SY_START]) begin
          st_next.reg_buffer_load = 1'b1;
          st_next.xfer_start = 1'b1;
          st_next.seq = S_PRESET_DEM;
        end
      end
      S_PRESET_DEM: begin
        // waits out drive initialise so the preset is not lost in the drive's reset
        if (st_reg.drive_ctl.demand && rise[SY_XFER]) begin
          st_next.drive_ctl.demand = 1'b0;
          st_next.seq = S_PRESET_REL;
        end else if (!st_reg.drive_init_out && !st_reg.reg_buffer_load) begin
          st_next.drive_ctl.demand = 1'b1;
        end
      end
      S_PRESET_REL: begin
        if (!st_reg.sync2[SY_XFER]) begin
          st_next.seq = S_WAIT_CTL;
        end
      end
      S_WAIT_CTL: begin
        // control request only once the channel has been seized
        if (st_reg.chan_pulse_seen && !st_reg.ctl_cycle_req) begin
          st_next.ctl_cycle_req = 1'b1;
        end
        if (st_reg.ctl_cycle_req) begin
          st_next.drive_ctl.data = CMD_READ;
          st_next.drive_ctl.reg_addr = DRV_REG_CTRL;
          st_next.drive_ctl.write = 1'b1;
          st_next.drive_ctl.demand = 1'b1;
          st_next.seq = S_CTL_DEM;
        end
      end
      S_CTL_DEM: begin
        if (rise[SY_XFER]) begin
          st_next.drive_ctl.demand = 1'b0;
          st_next.ctl_cycle_req = 1'b0;
          st_next.seq = S_CTL_REL;
        end
      end
      S_CTL_REL: begin
        if (!st_reg.sync2[SY_XFER]) begin
          st_next.drive_ctl.write = 1'b0;
          st_next.run = 1'b1;
          st_next.ctl_busy_flag = 1'b1;
          st_next.seq = S_RUN;
        end
      end
      S_RUN: begin
        if (st_reg.sync2[SY_OCC]) begin
          st_next.seq = S_DATA;
        end
      end
      S_DATA: begin
        // one word per sync clock; data has been held through two stages like the clock
        if (rise[SY_SCLK] && st_reg.ctl_busy_flag) begin
          st_next.bus_data_reg = st_reg.data_s2;
          st_next.assembly_reg = st_reg.data_s2;
          if (st_reg.chan_active_flag) begin
            st_next.channel_buffer = st_reg.data_s2;
            st_next.dev_word_pulse = 1'b1;
          end else if (!st_reg.chan_buf_full) begin
            st_next.channel_buffer = st_reg.data_s2;
            st_next.chan_buf_full = 1'b1;
          end else if (!st_reg.ar_full) begin
            st_next.ar_full = 1'b1;
          end else begin
            st_next.assembly_reg = st_reg.assembly_reg; // surplus words are dropped
          end
        end
        if (st_reg.xfer_complete && st_reg.chan_buf_full && st_reg.ar_full) begin
          st_next.boot_xfer_done = 1'b1;
          st_next.boot_word_ready = 1'b1;
          st_next.seq = S_PTR_READY;
        end
      end
      S_PTR_READY: begin
        if (rise[SY_CPU_DATA_IN]) begin
          st_next.boot_read_seen = 1'b1;
        end
        if (fall[SY_CPU_DATA_IN] && st_reg.boot_read_seen) begin
          st_next.chan_buf_full = 1'b0;
          st_next.boot_word_ready = 1'b0;
          st_next.seq = S_LAST_LOAD;
        end
      end
      S_LAST_LOAD: begin
        if (st_reg.ar_full && !st_reg.chan_buf_full) begin
          st_next.chan_buf_load = 1'b1;
          st_next.channel_buffer = st_reg.assembly_reg;
          st_next.chan_buf_full = 1'b1;
          st_next.ar_full = 1'b0;
          st_next.boot_word_ready = 1'b1;
          st_next.seq = S_LAST_READY;
        end
      end
      S_LAST_READY: begin
        if (rise[SY_CPU_DATA_IN]) begin
          st_next.boot_read_seen = 1'b0;
          st_next.boot_word_ready = 1'b0;
        end
        if (fall[SY_CPU_DATA_IN] && !st_reg.boot_read_seen) begin
          st_next.boot_end_pulse = 1'b1;
          st_next.boot_active_flag = 1'b0;
          st_next.chan_boot_mode = 1'b0;
          st_next.chan_buf_full = 1'b0;
          // a stale stored pulse would raise the next control request before the grant
          st_next.chan_pulse_seen = 1'b0;
          st_next.chan_pulse_flag = 1'b0;
          st_next.seq = S_IDLE;
        end
      end
      default: st_next.seq = S_IDLE;
    endcase

    // bus reset overrides everything: clears the sequence and all status flags
    if (rise[SY_RESET]) begin
      st_next.power_clear = 1'b1;
      st_next.init_cnt = INIT_CNT_W'(INIT_CYC);
      st_next.drive_init_out = 1'b1;
      st_next.seq = S_IDLE;
      st_next.boot_active_flag = 1'b0;
      st_next.boot_read_seen = 1'b0;
      st_next.boot_word_ready = 1'b0;
      st_next.drive_ctl = '0;
      st_next.ctl_cycle_req = 1'b0;
      st_next.run = 1'b0;
      st_next.chan_request_pending = 1'b0;
      st_next.chan_active_flag = 1'b0;
      st_next.chan_start_out = 1'b0;
      st_next.chan_seized = 1'b0;
      st_next.chan_boot_mode = 1'b0;
      st_next.chan_pulse_flag = 1'b0;
      st_next.chan_pulse_seen = 1'b0;
      st_next.chan_buf_full = 1'b0;
      st_next.ar_full = 1'b0;
      st_next.ctl_busy_flag = 1'b0;
      st_next.ctl_done_flag = 1'b0;
      st_next.xfer_terminate = 1'b0;
      st_next.xfer_complete = 1'b0;
    end
  end

  // single state register, synchronous reset to all zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // every output taken straight from the state register
  assign wb_dat_o = st_reg.wb_dat;
  assign wb_ack_o = st_reg.wb_ack;
  assign boot_word_ready_out_o = st_reg.boot_word_ready;
  assign cpu_data_o = st_reg.channel_buffer;
  assign power_clear_o = st_reg.power_clear;
  assign chan_start_out_o = st_reg.chan_start_out;
  assign chan_boot_mode_o = st_reg.chan_boot_mode;
  assign dev_word_pulse_o = st_reg.dev_word_pulse;
  assign chan_data_o = st_reg.channel_buffer;
  assign drive_ctl_o = st_reg.drive_ctl;
  assign drive_run_o = st_reg.run;
  assign drive_init_out_o = st_reg.drive_init_out;

endmodule

/* File: drive_model.sv */
// behavioural disk drive on the far side of the drive bus
`timescale 1ns/1ps
module drive_model (
  input wire boot_seq_pkg::drive_ctl_s drive_ctl_i,
  input wire logic drive_run_i,
  output logic drive_transfer_o,
  output logic drive_occupied_o,
  output logic drive_sclk_o,
  output logic end_of_block_o,
  output boot_seq_pkg::word_t drive_data_o
);
  import boot_seq_pkg::*;
  word_t words [5];
  int gap;
  logic slow;
  drive_ctl_s cmds [$];
  // block: control word, two data words, pointer of count -1 and address -1, last word
  initial begin
    words = '{36'h7fffc1000, 36'h123456789, 36'h0a5a5a5a5, 36'hfffffffff, 36'h254000100};
    gap = 1;
    slow = 1'b0;
    drive_transfer_o = 1'b0;
    drive_occupied_o = 1'b0;
    drive_sclk_o = 1'b0;
    end_of_block_o = 1'b0;
    drive_data_o = '0;
  end
  // control bus: answer each demand, promptly or slowly, and log what was written
  always @(posedge drive_ctl_i.demand) begin
    #(slow ? 303 : 33);
    cmds.push_back(drive_ctl_i);
    drive_transfer_o = 1'b1;
    @(negedge drive_ctl_i.demand);
    #23 drive_transfer_o = 1'b0;
  end
  // data bus: occupied on run, one word per sync clock, sync clock still between words
  always @(posedge drive_run_i) begin
    // 3 ns offset keeps every delayed pin change off the system clock edge; occupied drops with end of block, by which time run has already ended
    #53 drive_occupied_o = 1'b1;
    #60;
    foreach (words[n]) begin
      #(80 * (gap - 1)) drive_data_o = words[n];
      #20 drive_sclk_o = 1'b1;
      #40 drive_sclk_o = 1'b0;
      // hold time over: show the inverse so a late sample cannot pass
      drive_data_o = ~words[n];
      #20;
    end
    #100 end_of_block_o = 1'b1;
    #200 end_of_block_o = 1'b0;
    wait (!drive_run_i);
    drive_occupied_o = 1'b0;
  end
endmodule

/* File: tb.sv */
// self-checking bench for the bootstrap read-in sequencer
`timescale 1ns/1ps
module tb;
  import boot_seq_pkg::*;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [ADR_W-1:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic iob_reset_i, boot_start_pulse_i, cpu_data_in_i, boot_word_ready_out_o, power_clear_o;
  logic [DEV_CODE_W-1:0] iob_dev_code_i;
  word_t cpu_data_o, chan_data_o, drive_data_i;
  logic chan_granted_in_i, chan_start_out_o, chan_boot_mode_o, dev_word_pulse_o;
  drive_ctl_s drive_ctl_o;
  logic drive_transfer_i, drive_run_o, drive_init_out_o, drive_occupied_i, drive_sclk_i, end_of_block_i;
  int miscompares, num_checks, i, k;

  drive_bootstrap_readin_sequencer drive_bootstrap_readin_sequencer_i (.clk_i, .rst_i, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .iob_reset_i,
    .boot_start_pulse_i, .iob_dev_code_i, .cpu_data_in_i, .boot_word_ready_out_o, .cpu_data_o,
    .power_clear_o, .chan_granted_in_i, .chan_start_out_o, .chan_boot_mode_o, .dev_word_pulse_o,
    .chan_data_o, .drive_ctl_o, .drive_transfer_i, .drive_run_o, .drive_init_out_o, .drive_occupied_i,
    .drive_sclk_i, .end_of_block_i, .drive_data_i);
  drive_model drive_model_i (.drive_ctl_i(drive_ctl_o), .drive_run_i(drive_run_o),
    .drive_transfer_o(drive_transfer_i), .drive_occupied_o(drive_occupied_i),
    .drive_sclk_o(drive_sclk_i), .end_of_block_o(end_of_block_i), .drive_data_o(drive_data_i));

  // compare and count
  task chk(input string nm, input logic [35:0] seen, input logic [35:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task test_done;
    if (miscompares == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // one classic bus cycle; read data lands in q
  task wb(input logic we, input logic [ADR_W-1:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (wb_ack_o !== 1'b1 && i < 20);
    chk("wb_ack", wb_ack_o, 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  // start pulse with the code held steady beforehand
  task start(input logic [DEV_CODE_W-1:0] c);
    iob_dev_code_i <= c;
    repeat (3) @(posedge clk_i);
    boot_start_pulse_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    boot_start_pulse_i <= 1'b0;
  endtask

  task t_regs;
    wb(1'b1, ADR_CTRL, 32'h5);
    wb(1'b0, ADR_CTRL, 32'h0);
    chk("ctrl", q[2:0], 3'h5);
    wb(1'b1, ADR_STATUS, 32'hffffffff);
    wb(1'b0, ADR_STATUS, 32'h0);
    chk("status_ro", q, 32'h0);
    wb(1'b0, ADR_WORD_MASK, 32'h0);
    chk("unmapped", q, 32'h0);
  endtask

  // a foreign select code must leave the sequencer idle
  task t_wrong_code;
    start(BOOT_DEV_CODE ^ 9'h001);
    k = 0;
    repeat (40) begin
      @(posedge clk_i);
      if (chan_start_out_o === 1'b1 || drive_ctl_o.demand === 1'b1) k = 1;
    end
    chk("refused", k, 0);
  endtask

  // done was left set by the previous boot, so this also proves the clear
  task t_bus_reset;
    iob_reset_i <= 1'b1;
    for (i = 0; i < 10 && power_clear_o !== 1'b1; i++) @(posedge clk_i);
    chk("pclr", power_clear_o, 1'b1);
    iob_reset_i <= 1'b0;
    for (i = 0; i < 10 && drive_init_out_o !== 1'b1; i++) @(posedge clk_i);
    for (k = 0; k < 100 && drive_init_out_o === 1'b1; k++) @(posedge clk_i);
    chk("init_len", k, INIT_CYC);
    wb(1'b0, ADR_STATUS, 32'h0);
    chk("status_clr", q, 32'h0);
  endtask

  // whole read-in; the bench plays channel and processor
  task t_boot(input int gap, input logic slow);
    drive_model_i.gap = gap;
    drive_model_i.slow = slow;
    drive_model_i.cmds.delete();
    start(BOOT_DEV_CODE);
    for (i = 0; i < 100 && chan_start_out_o !== 1'b1; i++) @(posedge clk_i);
    chk("start_out", chan_start_out_o, 1'b1);
    chan_granted_in_i <= 1'b1;
    for (i = 0; i < 20 && chan_boot_mode_o !== 1'b1; i++) @(posedge clk_i);
    chk("boot_mode", chan_boot_mode_o, 1'b1);
    wb(1'b0, ADR_STATUS, 32'h0);
    chk("seized", {q[5], q[3]}, 2'b10);
    k = 0;
    for (i = 0; i < 5000 && k < 3; i++) begin
      @(posedge clk_i);
      if (dev_word_pulse_o === 1'b1) begin
        chk("chan_word", chan_data_o, drive_model_i.words[k]);
        k++;
      end
    end
    chk("chan_words", k, 3);
    // channel terminates; two more words stay in the controller
    chan_granted_in_i <= 1'b0;
    for (i = 0; i < 5000 && boot_word_ready_out_o !== 1'b1; i++) @(posedge clk_i);
    chk("ptr_ready", boot_word_ready_out_o, 1'b1);
    chk("run_off", drive_run_o, 1'b0);
    chk("cmd_count", drive_model_i.cmds.size(), 2);
    chk("ptr_word", cpu_data_o, drive_model_i.words[3]);
    chk("preset", drive_model_i.cmds[0], {3'h5, DRV_REG_CTRL, CMD_PRESET, 2'b11});
    chk("read", drive_model_i.cmds[1], {3'h5, DRV_REG_CTRL, CMD_READ, 2'b11});
    wb(1'b0, ADR_STATUS, 32'h0);
    chk("done", q[2:0], 3'b101);
    cpu_data_in_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    chk("ready_hold", boot_word_ready_out_o, 1'b1);
    cpu_data_in_i <= 1'b0;
    for (i = 0; i < 20 && boot_word_ready_out_o !== 1'b0; i++) @(posedge clk_i);
    chk("ready_clr", boot_word_ready_out_o, 1'b0);
    for (i = 0; i < 20 && boot_word_ready_out_o !== 1'b1; i++) @(posedge clk_i);
    chk("ready_again", boot_word_ready_out_o, 1'b1);
    chk("last_word", cpu_data_o, drive_model_i.words[4]);
    wb(1'b0, ADR_DATA, 32'h0);
    chk("data_reg", q, drive_model_i.words[4][31:0]);
    cpu_data_in_i <= 1'b1;
    for (i = 0; i < 20 && boot_word_ready_out_o !== 1'b0; i++) @(posedge clk_i);
    chk("ready_end", boot_word_ready_out_o, 1'b0);
    cpu_data_in_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    wb(1'b0, ADR_STATUS, 32'h0);
    chk("boot_end", {q[7], q[0]}, 2'b00);
    chk("mode_end", chan_boot_mode_o, 1'b0);
  endtask

  // 100 MHz system clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // main sequence: prompt drive first, slow drive after a bus reset
  initial begin
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, iob_reset_i, boot_start_pulse_i} = 6'h20;
    {cpu_data_in_i, chan_granted_in_i} = 2'b00;
    wb_adr_i = '0;
    wb_sel_i = '0;
    wb_dat_i = '0;
    iob_dev_code_i = '0;
    miscompares = 0;
    num_checks = 0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    t_regs;
    t_wrong_code;
    t_boot(1, 1'b0);
    t_bus_reset;
    t_boot(4, 1'b1);
    test_done;
  end

  // both boots need well under 10k cycles; cut off at 40k
  initial begin
    #400000;
    miscompares++;
    test_done;
  end
endmodule
